// [hw/bstp_regs.svh]
// Constants of the boundary-scan test port: widths, reset values and link timing.
// Assumes it is included by the package and by both ends of the test link.
// Function
// - Controller state changes only on test clock edges.
// - Mode select sampled at test clock rising edge.
// - Serial input shifted in on rising edge.
// - Serial output updated on falling edge.
// - Only external-test and floated-sample disturb memory.
// - One instruction register, several selectable data registers.
// - Unused port: clock low, select and input high.
// - Sixteen states; reset on power-up or five ones.
// - Instruction loads identification code; update applies new.
// - Three-bit instruction decode; reserved codes select bypass.
// - Input sampled, output driven only in shift states.
`ifndef BSTP_REGS_SVH
`define BSTP_REGS_SVH

// ****************************************************************
// Register widths
// ****************************************************************
`define BSTP_IR_W 3
`define BSTP_ID_W 32
`define BSTP_BSR_LEN 8

// ****************************************************************
// Reset values and link timing
// ****************************************************************
`define BSTP_ID_RESET 32'h0ABC_D001
`define BSTP_TLR_ONES 5
`define BSTP_TCK_HALF 4'h8
`define BSTP_CNT_W 4

`endif

// [hw/bstp_pkg.sv]
// Types shared by both ends of the boundary-scan test link.
// Assumes bstp_regs.svh is on the include path.
`include "bstp_regs.svh"

package bstp_pkg;

	// ****************************************************************
	// Controller states, Gray-coded along the usual walk
	// ****************************************************************
	typedef enum logic [3:0] {
		ST_RESET = 4'h0, ST_IDLE = 4'h1, ST_SEL_DR = 4'h3, ST_CAP_DR = 4'h2,
		ST_SHIFT_DR = 4'h6, ST_EXIT1_DR = 4'h7, ST_PAUSE_DR = 4'h5, ST_EXIT2_DR = 4'h4,
		ST_UPD_DR = 4'hC, ST_SEL_IR = 4'hD, ST_CAP_IR = 4'hF, ST_SHIFT_IR = 4'hE,
		ST_EXIT1_IR = 4'hA, ST_PAUSE_IR = 4'hB, ST_EXIT2_IR = 4'h9, ST_UPD_IR = 4'h8
	} bstp_state_e;

	typedef enum logic [2:0] {
		INS_EXTERNAL_INTERCONNECT_TEST = 3'h0,
		INS_IDENTIFICATION_INSTRUCTION = 3'h1,
		INS_SAMPLE_FLOAT = 3'h2,
		INS_SAMPLE = 3'h4
	} bstp_instr_e;

	typedef enum logic [1:0] {
		DR_BYPASS = 2'h0,
		DR_IDENT = 2'h1,
		DR_BOUNDARY = 2'h3
	} bstp_dr_e;

	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_LOW = 2'h1,
		CS_HIGH = 2'h3
	} bstp_ctl_e;

	// Sixteen-state walk; five ones from anywhere reach ST_RESET.
	function automatic bstp_state_e bstp_next(input bstp_state_e s, input logic tms);
		case (s)
			ST_RESET: bstp_next = tms ? ST_RESET : ST_IDLE;
			ST_IDLE: bstp_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_DR: bstp_next = tms ? ST_SEL_IR : ST_CAP_DR;
			ST_CAP_DR: bstp_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_SHIFT_DR: bstp_next = tms ? ST_EXIT1_DR : ST_SHIFT_DR;
			ST_EXIT1_DR: bstp_next = tms ? ST_UPD_DR : ST_PAUSE_DR;
			ST_PAUSE_DR: bstp_next = tms ? ST_EXIT2_DR : ST_PAUSE_DR;
			ST_EXIT2_DR: bstp_next = tms ? ST_UPD_DR : ST_SHIFT_DR;
			ST_UPD_DR: bstp_next = tms ? ST_SEL_DR : ST_IDLE;
			ST_SEL_IR: bstp_next = tms ? ST_RESET : ST_CAP_IR;
			ST_CAP_IR: bstp_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_SHIFT_IR: bstp_next = tms ? ST_EXIT1_IR : ST_SHIFT_IR;
			ST_EXIT1_IR: bstp_next = tms ? ST_UPD_IR : ST_PAUSE_IR;
			ST_PAUSE_IR: bstp_next = tms ? ST_EXIT2_IR : ST_PAUSE_IR;
			ST_EXIT2_IR: bstp_next = tms ? ST_UPD_IR : ST_SHIFT_IR;
			ST_UPD_IR: bstp_next = tms ? ST_SEL_DR : ST_IDLE;
			default: bstp_next = ST_RESET;
		endcase
	endfunction : bstp_next

endpackage : bstp_pkg

// [hw/bstp_if.sv]
// The four-wire test link between the tester end and the device end.
// Assumes each end drives only the signals of its own modport.
`timescale 1ns/1ps

interface bstp_if;
	logic tck;
	logic tms;
	logic tdi;
	logic tdo;
	logic tdo_oe_n;
	logic tdo_line;

	// The serial output floats outside shift states; the line then reads high.
	assign tdo_line = tdo_oe_n ? 1'b1 : tdo;

	modport dev (input tck, input tms, input tdi, output tdo, output tdo_oe_n);
	modport ctl (output tck, output tms, output tdi, input tdo_line);
endinterface : bstp_if

// [hw/bstp_dev.sv]
// Device end of the boundary-scan test port: controller, instruction and data registers.
// Assumes the test clock is far slower than I_REF_CLK and that I_RING_IN is on I_REF_CLK.
`timescale 1ns/1ps
`include "bstp_regs.svh"

module bstp_dev #(
	// Arbitrary identification value; bit 0 is one as a test chain expects.
	parameter logic [`BSTP_ID_W-1:0] ID_CODE = `BSTP_ID_RESET
) (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	// Test link
	bstp_if.dev LINK,
	// Memory I/O ring
	input wire logic [`BSTP_BSR_LEN-1:0] I_RING_IN,
	output logic [`BSTP_BSR_LEN-1:0] O_RING_OUT,
	output logic O_RING_DRIVE_EN,
	output logic O_DQ_FLOAT,
	output logic O_ODT_OFF
);

	// ****************************************************************
	// Input synchronisers and test clock edges
	// ****************************************************************
	logic [1:0] tck_sync_r;
	logic [1:0] tms_sync_r;
	logic [1:0] tdi_sync_r;
	logic tck_d_r;
	logic tck_rise;
	logic tck_fall;
	logic tms_s;
	logic tdi_s;

	// All three pins pass the same two stages, so the sampled select and
	// data keep their alignment with the detected clock edge.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			tck_sync_r <= 2'h0;
			tms_sync_r <= 2'h3;
			tdi_sync_r <= 2'h3;
		end
		else
		begin
			tck_sync_r <= {tck_sync_r[0], LINK.tck};
			tms_sync_r <= {tms_sync_r[0], LINK.tms};
			tdi_sync_r <= {tdi_sync_r[0], LINK.tdi};
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			tck_d_r <= 1'b0;
		else
			tck_d_r <= tck_sync_r[1];
	end

	assign tck_rise = tck_sync_r[1] & ~tck_d_r;
	assign tck_fall = ~tck_sync_r[1] & tck_d_r;
	assign tms_s = tms_sync_r[1];
	assign tdi_s = tdi_sync_r[1];

	// ****************************************************************
	// Controller
	// ****************************************************************
	bstp_pkg::bstp_state_e state_r;

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			state_r <= bstp_pkg::ST_RESET;
		else if (tck_rise)
			state_r <= bstp_pkg::bstp_next(state_r, tms_s);
	end

	// ****************************************************************
	// Instruction register
	// ****************************************************************
	logic [`BSTP_IR_W-1:0] ir_sh_r;
	logic [`BSTP_IR_W-1:0] ir_act_r;

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			ir_sh_r <= bstp_pkg::INS_IDENTIFICATION_INSTRUCTION;
		else if (tck_rise)
		begin
			case (state_r)
				bstp_pkg::ST_RESET, bstp_pkg::ST_CAP_IR:
					ir_sh_r <= bstp_pkg::INS_IDENTIFICATION_INSTRUCTION;
				bstp_pkg::ST_SHIFT_IR:
					ir_sh_r <= {tdi_s, ir_sh_r[`BSTP_IR_W-1:1]};
				default:
					ir_sh_r <= ir_sh_r;
			endcase
		end
	end

	// A shifted instruction stays inert until the update state is reached.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			ir_act_r <= bstp_pkg::INS_IDENTIFICATION_INSTRUCTION;
		else if (state_r == bstp_pkg::ST_RESET)
			ir_act_r <= bstp_pkg::INS_IDENTIFICATION_INSTRUCTION;
		else if (tck_fall && state_r == bstp_pkg::ST_UPD_IR)
			ir_act_r <= ir_sh_r;
	end

	// ****************************************************************
	// Instruction decode
	// ****************************************************************
	bstp_pkg::bstp_dr_e dr_sel;

	// Reserved codes fall back to the one-bit bypass path.
	always_comb
	begin
		case (ir_act_r)
			bstp_pkg::INS_EXTERNAL_INTERCONNECT_TEST,
			bstp_pkg::INS_SAMPLE_FLOAT,
			bstp_pkg::INS_SAMPLE:
				dr_sel = bstp_pkg::DR_BOUNDARY;
			bstp_pkg::INS_IDENTIFICATION_INSTRUCTION:
				dr_sel = bstp_pkg::DR_IDENT;
			default:
				dr_sel = bstp_pkg::DR_BYPASS;
		endcase
	end

	// ****************************************************************
	// Data registers
	// ****************************************************************
	logic [`BSTP_ID_W-1:0] id_sh_r;
	logic [`BSTP_BSR_LEN-1:0] bsr_sh_r;
	logic byp_sh_r;

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			id_sh_r <= '0;
			bsr_sh_r <= '0;
			byp_sh_r <= 1'b0;
		end
		else if (tck_rise && state_r == bstp_pkg::ST_CAP_DR)
		begin
			id_sh_r <= ID_CODE;
			bsr_sh_r <= I_RING_IN;
			byp_sh_r <= 1'b0;
		end
		else if (tck_rise && state_r == bstp_pkg::ST_SHIFT_DR)
		begin
			case (dr_sel)
				bstp_pkg::DR_IDENT:
					id_sh_r <= {tdi_s, id_sh_r[`BSTP_ID_W-1:1]};
				bstp_pkg::DR_BOUNDARY:
					bsr_sh_r <= {tdi_s, bsr_sh_r[`BSTP_BSR_LEN-1:1]};
				default:
					byp_sh_r <= tdi_s;
			endcase
		end
	end

	// Update latch for the ring outputs; it reaches the pins only under
	// external test, so sampling alone never disturbs the memory.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			O_RING_OUT <= '0;
		else if (state_r == bstp_pkg::ST_RESET)
			O_RING_OUT <= '0;
		else if (tck_fall && state_r == bstp_pkg::ST_UPD_DR && dr_sel == bstp_pkg::DR_BOUNDARY)
			O_RING_OUT <= bsr_sh_r;
	end

	// ****************************************************************
	// Serial output
	// ****************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			LINK.tdo <= 1'b0;
			LINK.tdo_oe_n <= 1'b1;
		end
		else if (tck_fall)
		begin
			case (state_r)
				bstp_pkg::ST_SHIFT_IR:
				begin
					LINK.tdo <= ir_sh_r[0];
					LINK.tdo_oe_n <= 1'b0;
				end
				bstp_pkg::ST_SHIFT_DR:
				begin
					case (dr_sel)
						bstp_pkg::DR_IDENT: LINK.tdo <= id_sh_r[0];
						bstp_pkg::DR_BOUNDARY: LINK.tdo <= bsr_sh_r[0];
						default: LINK.tdo <= byp_sh_r;
					endcase
					LINK.tdo_oe_n <= 1'b0;
				end
				default:
					LINK.tdo_oe_n <= 1'b1;
			endcase
		end
	end

	// ****************************************************************
	// Effects on normal memory operation
	// ****************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_RING_DRIVE_EN <= 1'b0;
			O_DQ_FLOAT <= 1'b0;
			O_ODT_OFF <= 1'b0;
		end
		else
		begin
			O_RING_DRIVE_EN <= ir_act_r == bstp_pkg::INS_EXTERNAL_INTERCONNECT_TEST;
			O_DQ_FLOAT <= ir_act_r == bstp_pkg::INS_SAMPLE_FLOAT;
			O_ODT_OFF <= ir_act_r == bstp_pkg::INS_EXTERNAL_INTERCONNECT_TEST
				|| ir_act_r == bstp_pkg::INS_SAMPLE_FLOAT;
		end
	end

endmodule : bstp_dev

// [hw/bstp_ctl.sv]
// Tester end of the boundary-scan test link: makes the test clock and runs one bit per request.
// Assumes the device end samples the link on I_REF_CLK with two-stage synchronisers.
`timescale 1ns/1ps
`include "bstp_regs.svh"

module bstp_ctl (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	// Bit request
	input wire logic I_REQ,
	input wire logic I_TMS,
	input wire logic I_TDI,
	output logic O_READY,
	output logic O_DONE,
	output logic O_TDO,
	// Test link
	bstp_if.ctl LINK
);

	// ****************************************************************
	// Serial output synchroniser
	// ****************************************************************
	logic [1:0] tdo_sync_r;

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			tdo_sync_r <= 2'h3;
		else
			tdo_sync_r <= {tdo_sync_r[0], LINK.tdo_line};
	end

	// ****************************************************************
	// Clock divider and bit sequencer
	// ****************************************************************
	// The half period is long enough that the device's falling-edge output,
	// delayed by both synchronisers, settles before the next rising edge.
	bstp_pkg::bstp_ctl_e state_r;
	logic [`BSTP_CNT_W-1:0] cnt_r;
	logic half_end;

	assign half_end = cnt_r == `BSTP_TCK_HALF - 4'h1;

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			cnt_r <= '0;
		else if (state_r == bstp_pkg::CS_IDLE || half_end)
			cnt_r <= '0;
		else
			cnt_r <= cnt_r + 4'h1;
	end

	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
			state_r <= bstp_pkg::CS_IDLE;
		else
		begin
			case (state_r)
				bstp_pkg::CS_IDLE:
					if (I_REQ)
						state_r <= bstp_pkg::CS_LOW;
				bstp_pkg::CS_LOW:
					if (half_end)
						state_r <= bstp_pkg::CS_HIGH;
				bstp_pkg::CS_HIGH:
					if (half_end)
						state_r <= I_REQ ? bstp_pkg::CS_LOW : bstp_pkg::CS_IDLE;
				default:
					state_r <= bstp_pkg::CS_IDLE;
			endcase
		end
	end

	// Select and data change only while the clock is low, so they are
	// steady across the rising edge; between bits the clock rests low.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			LINK.tck <= 1'b0;
			LINK.tms <= 1'b1;
			LINK.tdi <= 1'b1;
		end
		else
		begin
			if ((state_r == bstp_pkg::CS_IDLE || (state_r == bstp_pkg::CS_HIGH && half_end)) && I_REQ)
			begin
				LINK.tms <= I_TMS;
				LINK.tdi <= I_TDI;
			end
			if (state_r == bstp_pkg::CS_LOW && half_end)
				LINK.tck <= 1'b1;
			else if (state_r == bstp_pkg::CS_HIGH && half_end)
				LINK.tck <= 1'b0;
		end
	end

	// ****************************************************************
	// Request answer
	// ****************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			O_TDO <= 1'b1;
			O_DONE <= 1'b0;
			O_READY <= 1'b1;
		end
		else
		begin
			if (state_r == bstp_pkg::CS_LOW && half_end)
				O_TDO <= tdo_sync_r[1];
			O_DONE <= state_r == bstp_pkg::CS_HIGH && half_end;
			if (state_r == bstp_pkg::CS_IDLE && I_REQ)
				O_READY <= 1'b0;
			else if (state_r == bstp_pkg::CS_HIGH && half_end)
				O_READY <= 1'b1;
		end
	end

endmodule : bstp_ctl

// [tb/bstp_link_monitor.sv]
// Concurrent checks on the four-wire test link between the two ends.
// Assumes the bench instantiates it beside the link with the reference clock and reset.
`timescale 1ns/1ps

module bstp_link_monitor (
	// Clock and reset
	input wire logic I_REF_CLK,
	input wire logic I_RSTN,
	// Test link
	input wire logic tck,
	input wire logic tms,
	input wire logic tdi,
	input wire logic tdo,
	input wire logic tdo_oe_n,
	input wire logic tdo_line
);
	logic tck_q_r;
	logic [2:0] ones_r;

	default clocking @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RSTN);

	// ****************************************************************
	// Run of rising test clock edges seen with mode select high
	// ****************************************************************
	// The count saturates so that a long run of ones never wraps back to a low value.
	always_ff @(posedge I_REF_CLK or negedge I_RSTN)
	begin
		if (!I_RSTN)
		begin
			tck_q_r <= 1'h0;
			ones_r <= 3'h0;
		end
		else
		begin
			tck_q_r <= tck;
			if (tck && !tck_q_r)
				ones_r <= !tms ? 3'h0 : (ones_r == 3'h7 ? 3'h7 : ones_r + 3'h1);
		end
	end

	// ****************************************************************
	// Link assertions
	// ****************************************************************
	tck_high_a: assert property ($rose(tck) |-> tck [*8] ##1 !tck)
		else $error("test clock high phase is not eight cycles");
	tck_low_a: assert property ($fell(tck) |-> !tck [*8])
		else $error("test clock low phase shorter than eight cycles");
	tms_setup_a: assert property ($changed(tms) |-> !tck)
		else $error("mode select moved while test clock high");
	tdi_setup_a: assert property ($changed(tdi) |-> !tck)
		else $error("serial input moved while test clock high");
	tdo_fall_a: assert property (($changed(tdo) || $changed(tdo_oe_n)) |-> !tck && !$past(tck, 2))
		else $error("serial output changed away from a falling test clock");
	ones_float_a: assert property (ones_r >= 3'h5 |-> tdo_oe_n && tdo_line)
		else $error("serial output driven after five ones");
	shift_only_a: assert property (!tdo_oe_n |-> ones_r <= 3'h1)
		else $error("serial output driven outside a shift state");
	oe_hold_a: assert property ($fell(tdo_oe_n) |-> !tdo_oe_n [*8])
		else $error("serial output enable dropped too soon");
	idle_level_a: assert property ($rose(I_RSTN) |-> !tck && tms && tdi && tdo_oe_n)
		else $error("link not idle after reset");
endmodule : bstp_link_monitor

// [tb/tb.sv]
// Self-checking bench: tester end and device end joined by the test link.
// Assumes the design files are compiled first.
`timescale 1ns/1ps

module tb;
	// Arbitrary identification value with bit 0 set.
	localparam logic [31:0] TB_ID = 32'h5A5A_0F0F;
	logic ref_clk = 1'h0;
	logic rst_n = 1'h0;
	logic req = 1'h0;
	logic bit_tms = 1'h1;
	logic bit_tdi = 1'h1;
	logic ready;
	logic done;
	logic tdo_bit;
	logic [7:0] ring_in = 8'hA5;
	logic [7:0] ring_out;
	logic drive_en;
	logic dq_float;
	logic odt_off;
	logic [31:0] d;
	int err_count = 0;
	int compares = 0;

	bstp_if link();
	bstp_ctl u_bstp_ctl (.I_REF_CLK(ref_clk), .I_RSTN(rst_n), .I_REQ(req), .I_TMS(bit_tms), .I_TDI(bit_tdi),
		.O_READY(ready), .O_DONE(done), .O_TDO(tdo_bit), .LINK(link.ctl));
	bstp_dev #(.ID_CODE(TB_ID)) u_bstp_dev (.I_REF_CLK(ref_clk), .I_RSTN(rst_n), .LINK(link.dev),
		.I_RING_IN(ring_in), .O_RING_OUT(ring_out), .O_RING_DRIVE_EN(drive_en), .O_DQ_FLOAT(dq_float),
		.O_ODT_OFF(odt_off));
	bstp_link_monitor u_bstp_link_monitor (.I_REF_CLK(ref_clk), .I_RSTN(rst_n), .tck(link.tck), .tms(link.tms),
		.tdi(link.tdi), .tdo(link.tdo), .tdo_oe_n(link.tdo_oe_n), .tdo_line(link.tdo_line));

	always #25 ref_clk = ~ref_clk;

	// ****************************************************************
	// Shared tasks
	// ****************************************************************
	task automatic test_done;
	begin
		$display("Comparisons %0d, mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask : test_done

	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
	begin
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, got);
		end
	end
	endtask : check

	task automatic chk_modes(input logic [2:0] exp);
	begin
		check("drive, float, odt", {29'h0, exp}, {29'h0, drive_en, dq_float, odt_off});
	end
	endtask : chk_modes

	// One test clock bit; the request is dropped right after the edge that takes it.
	task automatic tap_bit(input logic tms, input logic tdi, output logic tdo);
		int n;
	begin
		n = 0;
		req = 1'h1;
		bit_tms = tms;
		bit_tdi = tdi;
		@(posedge ref_clk);
		#2 req = 1'h0;
		do
		begin
			@(posedge ref_clk);
			#2 n++;
		end
		while (done !== 1'h1 && n < 40);
		if (n >= 40)
		begin
			err_count++;
			$display("[FAIL] bit completion expected done seen timeout");
			test_done();
		end
		tdo = tdo_bit;
	end
	endtask : tap_bit

	// From idle through capture and shift back to idle; words go LSB first.
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic t;
	begin
		dout = 32'h0;
		tap_bit(1'h1, 1'h1, t);
		if (ir)
			tap_bit(1'h1, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		for (int i = 0; i < n; i++)
		begin
			tap_bit(i == n - 1, din[i], t);
			dout[i] = t;
		end
		tap_bit(1'h1, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
	end
	endtask : scan

	// ****************************************************************
	// Scenarios
	// ****************************************************************
	// The controller wakes in its reset state, so one low select bit brings it to idle first.
	task automatic t_ident_read;
		logic t;
	begin
		check("idle test clock", 32'h0, {31'h0, link.tck});
		check("idle select and input", 32'h3, {30'h0, link.tms, link.tdi});
		check("idle ready", 32'h1, {31'h0, ready});
		check("idle serial line", 32'h1, {31'h0, link.tdo_line});
		tap_bit(1'h0, 1'h1, t);
		scan(1'h0, 32, 32'h0, d);
		check("id after power up", TB_ID, d);
		chk_modes(3'h0);
		$display("t_ident_read done");
	end
	endtask : t_ident_read

	task automatic t_ir_capture;
	begin
		scan(1'h1, 3, 32'h4, d);
		check("ir capture", 32'h1, {29'h0, d[2:0]});
		scan(1'h0, 8, 32'h3C, d);
		check("boundary capture", 32'hA5, {24'h0, d[7:0]});
		check("boundary update", 32'h3C, {24'h0, ring_out});
		chk_modes(3'h0);
		$display("t_ir_capture done");
	end
	endtask : t_ir_capture

	// Every code, reserved ones included; bypass shows as a one-bit delay behind a zero.
	task automatic t_codes;
		logic [7:0] din;
		logic [7:0] exp;
	begin
		for (int c = 0; c < 8; c++)
		begin
			din = 8'hC3 ^ 8'(c);
			scan(1'h1, 3, 32'(c), d);
			scan(1'h0, 8, {24'h0, din}, d);
			case (c)
				0, 2, 4: exp = 8'hA5;
				1: exp = TB_ID[7:0];
				default: exp = {din[6:0], 1'h0};
			endcase
			check("dr path", {24'h0, exp}, {24'h0, d[7:0]});
			chk_modes({c == 0, c == 2, c == 0 || c == 2});
			if (c == 0 || c == 2 || c == 4)
				check("ring out", {24'h0, din}, {24'h0, ring_out});
		end
		$display("t_codes done");
	end
	endtask : t_codes

	// Shifting resumes after a pause; the serial line floats while paused.
	task automatic t_pause;
		logic t;
	begin
		scan(1'h1, 3, 32'h1, d);
		d = 32'h0;
		tap_bit(1'h1, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		for (int i = 0; i < 8; i++)
		begin
			tap_bit(i == 3 || i == 7, 1'h0, t);
			d[i] = t;
			if (i == 3)
			begin
				tap_bit(1'h0, 1'h1, t);
				tap_bit(1'h0, 1'h1, t);
				check("paused serial line", 32'h1, {31'h0, link.tdo_line});
				tap_bit(1'h1, 1'h1, t);
				tap_bit(1'h0, 1'h1, t);
			end
		end
		tap_bit(1'h1, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		check("id across pause", {24'h0, TB_ID[7:0]}, {24'h0, d[7:0]});
		$display("t_pause done");
	end
	endtask : t_pause

	task automatic t_five_ones;
		logic t;
	begin
		scan(1'h1, 3, 32'h0, d);
		tap_bit(1'h1, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		for (int i = 0; i < 4; i++)
			tap_bit(1'h1, 1'h1, t);
		chk_modes(3'h5);
		tap_bit(1'h1, 1'h1, t);
		tap_bit(1'h0, 1'h1, t);
		chk_modes(3'h0);
		check("ring out after reset", 32'h0, {24'h0, ring_out});
		scan(1'h0, 32, 32'h0, d);
		check("id after five ones", TB_ID, d);
		$display("t_five_ones done");
	end
	endtask : t_five_ones

	task automatic t_mid_reset;
		logic t;
	begin
		scan(1'h1, 3, 32'h2, d);
		chk_modes(3'h3);
		rst_n = 1'h0;
		repeat (4) @(posedge ref_clk);
		#2 rst_n = 1'h1;
		chk_modes(3'h0);
		tap_bit(1'h0, 1'h1, t);
		scan(1'h0, 32, 32'h0, d);
		check("id after reset", TB_ID, d);
		$display("t_mid_reset done");
	end
	endtask : t_mid_reset

	initial
	begin
		repeat (4) @(posedge ref_clk);
		#2 rst_n = 1'h1;
		t_ident_read();
		t_ir_capture();
		t_codes();
		t_pause();
		t_five_ones();
		t_mid_reset();
		test_done();
	end
endmodule : tb
